// ===== inc/pdxm_defs.vh
// Register map and field constants for the port data crossbar mux
`ifndef PDXM_DEFS_VH
`define PDXM_DEFS_VH
// Register word addresses (byte address = 4 * index)
`define PDXM_ADDR_W        4
`define PDXM_A_XBAR_DIR    4'h0
`define PDXM_A_XBAR_SEL    4'h1
`define PDXM_A_ORIENT      4'h2
`define PDXM_A_CMP_EN      4'h3
`define PDXM_A_PULL_UP     4'h4
`define PDXM_A_PULL_DN     4'h5
`define PDXM_A_PATH        4'h6
`define PDXM_A_EP_CTRL     4'h7
`define PDXM_A_BC_CTRL     4'h8
`define PDXM_A_BC_SW       4'h9
`define PDXM_A_IRQ_STAT    4'hA
`define PDXM_A_IRQ_MASK    4'hB
`define PDXM_A_PIN_STAT    4'hC
// Crossbar pin indices: 0 serial rx, 1 serial tx, 2 sb p2s, 3 sb s2p, 4 gp0, 5 gp1
`define PDXM_NPIN          6
`define PDXM_SRC_W         3
`define PDXM_SEL_W         18
// Reset: all pins inputs except serial tx output driven by serial rx
`define PDXM_DIR_RST       6'h02
`define PDXM_SEL_RST       18'h00000
// Port pin indices: 0 sb a, 1 sb b, 2 top dp, 3 top dm, 4 bot dp, 5 bot dm
`define PDXM_NPORT         6
// Endpoint control bits
`define PDXM_EP_EN         0
`define PDXM_EP_TX         1
`define PDXM_EP_DP         2
`define PDXM_EP_DM         3
// Charger detect phases
`define PDXM_BC_IDLE       2'h0
`define PDXM_BC_DCD        2'h1
`define PDXM_BC_PRI        2'h2
`define PDXM_BC_SEC        2'h3
`define PDXM_NSW           12
// Crossbar pin and port pin positions used by fixed routes
`define PDXM_PIN_RX        0
`define PDXM_PIN_TX        1
`define PDXM_PIN_GP0       4
`define PDXM_PIN_GP1       5
`define PDXM_PORT_TOP      2
`define PDXM_PORT_BOT      4
// One-hot pair selects steered by cable orientation
`define PDXM_SIDE_TOP      2'h1
`define PDXM_SIDE_BOT      2'h2
`endif

// ===== hw/pdxm_top.v
// Port data crossbar mux control core with Avalon-MM register slave
`timescale 1ns/1ps
`include "pdxm_defs.vh"
module pdxm_top #(
  parameter NPIN  = `PDXM_NPIN,
  parameter NPORT = `PDXM_NPORT
) (
  // Clock, reset, enable
  input  wire                      clk,
  input  wire                      rstn,
  input  wire                      ce,
  // Avalon-MM slave
  input  wire [`PDXM_ADDR_W-1:0]   avs_address,
  input  wire                      avs_read,
  input  wire                      avs_write,
  input  wire [31:0]               avs_writedata,
  output reg  [31:0]               avs_readdata,
  output reg                       avs_waitrequest,
  output reg                       irq,
  // Crossbar system pins (three-signal)
  input  wire [NPIN-1:0]           xbar_pin_in,
  output reg  [NPIN-1:0]           xbar_pin_out,
  output reg  [NPIN-1:0]           xbar_pin_oe_n,
  // Crossbar sideband signals to and from port data muxes
  output reg  [1:0]                sb_sys_to_port,
  output reg  [1:0]                sb_pin_drive,
  input  wire [1:0]                sideband_port_to_sys,
  // Port pin digital levels from comparators
  input  wire [NPORT-1:0]          port_level,
  // Analog controls
  output reg  [NPORT-1:0]          cmp_connect,
  output reg  [NPORT-1:0]          pull_up_en,
  output reg  [NPORT-1:0]          pull_dn_en,
  output reg  [NPORT-1:0]          path_closed,
  output reg  [NPORT-1:0]          clamp_connect,
  // Low-speed endpoint
  output reg  [1:0]                ep_drive,
  output reg                       ep_drive_en,
  output reg  [1:0]                ep_drive_sel,
  output reg  [1:0]                endpoint_pullup,
  output reg  [1:0]                ep_rx,
  // Charger detection
  output reg  [1:0]                contact_detect_current,
  output reg  [1:0]                contact_detect_pulldown,
  output reg  [`PDXM_NSW-1:0]      detect_sw,
  output reg                       detect_voltage_source,
  output reg                       detect_current_sink,
  output reg                       adc_sample_req
);

  // Control registers
  reg [NPIN-1:0]           dir_reg;
  reg [`PDXM_SEL_W-1:0]    sel_reg;
  reg                      orient_reg;
  reg [NPORT-1:0]          cmp_en_reg;
  reg [NPORT-1:0]          pu_reg;
  reg [NPORT-1:0]          pd_reg;
  reg [NPORT-1:0]          path_reg;
  reg [3:0]                ep_reg;
  reg [1:0]                bc_reg;
  reg [`PDXM_NSW-1:0]      sw_reg;
  reg [NPORT-1:0]          stat_reg;
  reg [NPORT-1:0]          mask_reg;
  reg                      ack_reg;

  // Synchronisers for outside inputs
  reg [NPIN-1:0]  pin_s1_reg;
  reg [NPIN-1:0]  pin_s2_reg;
  reg [1:0]       sb_s1_reg;
  reg [1:0]       sb_s2_reg;
  reg [NPORT-1:0] lvl_s1_reg;
  reg [NPORT-1:0] lvl_s2_reg;
  reg [NPORT-1:0] lvl_d_reg;

  // Source pick: 0..5 pins, 6/7 sideband inputs from port
  function src_pick;
    input [2:0]      s;
    input [NPIN-1:0] p;
    input [1:0]      sb;
    begin
      if (s[2] & s[1])
        src_pick = sb[s[0]];
      else
        src_pick = p[s];
    end
  endfunction

  // Top pair unless the cable is flipped; shared by the endpoint drive, pull-up and contact detect outputs
  function [1:0] side_sel;
    input flipped;
    begin
      side_sel = flipped ? `PDXM_SIDE_BOT : `PDXM_SIDE_TOP;
    end
  endfunction

  wire [NPORT-1:0] edge_evt = (lvl_s2_reg ^ lvl_d_reg) & cmp_en_reg;
  wire             acc      = (avs_read | avs_write) & avs_waitrequest & ~ack_reg;
  wire             wr       = acc & avs_write;
  wire [NPORT-1:0] clr      = (wr && avs_address == `PDXM_A_IRQ_STAT) ?
                              avs_writedata[NPORT-1:0] : {NPORT{1'b0}};

  reg [NPIN-1:0] xout;
  reg [1:0]      s2p;
  integer        i;
  always @* begin
    xout = {NPIN{1'b0}};
    for (i = 0; i < NPIN; i = i + 1)
      xout[i] = src_pick(sel_reg[i*3 +: 3], pin_s2_reg, sb_s2_reg);
    // Serial tx defaults to buffered serial rx at reset
    if (sel_reg[`PDXM_PIN_TX*`PDXM_SRC_W +: `PDXM_SRC_W] == {`PDXM_SRC_W{1'b0}})
      xout[`PDXM_PIN_TX] = pin_s2_reg[`PDXM_PIN_RX];
    s2p = {src_pick(sel_reg[`PDXM_PIN_GP1*`PDXM_SRC_W +: `PDXM_SRC_W], pin_s2_reg, sb_s2_reg),
           src_pick(sel_reg[`PDXM_PIN_GP0*`PDXM_SRC_W +: `PDXM_SRC_W], pin_s2_reg, sb_s2_reg)};
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dir_reg         <= `PDXM_DIR_RST;
      sel_reg         <= `PDXM_SEL_RST;
      orient_reg      <= 1'b0;
      cmp_en_reg      <= {NPORT{1'b0}};
      pu_reg          <= {NPORT{1'b0}};
      pd_reg          <= {NPORT{1'b0}};
      path_reg        <= {NPORT{1'b0}};
      ep_reg          <= 4'h0;
      bc_reg          <= `PDXM_BC_IDLE;
      sw_reg          <= {`PDXM_NSW{1'b0}};
      stat_reg        <= {NPORT{1'b0}};
      mask_reg        <= {NPORT{1'b0}};
      ack_reg         <= 1'b0;
      avs_readdata    <= 32'h00000000;
      avs_waitrequest <= 1'b1;
      pin_s1_reg      <= {NPIN{1'b0}};
      pin_s2_reg      <= {NPIN{1'b0}};
      sb_s1_reg       <= 2'h0;
      sb_s2_reg       <= 2'h0;
      lvl_s1_reg      <= {NPORT{1'b0}};
      lvl_s2_reg      <= {NPORT{1'b0}};
      lvl_d_reg       <= {NPORT{1'b0}};
    end else if (ce) begin
      pin_s1_reg <= xbar_pin_in;
      pin_s2_reg <= pin_s1_reg;
      sb_s1_reg  <= sideband_port_to_sys;
      sb_s2_reg  <= sb_s1_reg;
      lvl_s1_reg <= port_level;
      lvl_s2_reg <= lvl_s1_reg;
      lvl_d_reg  <= lvl_s2_reg;
      // Set wins over clear
      stat_reg <= (stat_reg & ~clr) | edge_evt;
      // One wait cycle, then answer; release waitrequest one cycle
      ack_reg         <= acc;
      avs_waitrequest <= ~acc;
      if (wr) begin
        case (avs_address)
          `PDXM_A_XBAR_DIR: dir_reg    <= avs_writedata[NPIN-1:0];
          `PDXM_A_XBAR_SEL: sel_reg    <= avs_writedata[`PDXM_SEL_W-1:0];
          `PDXM_A_ORIENT:   orient_reg <= avs_writedata[0];
          `PDXM_A_CMP_EN:   cmp_en_reg <= avs_writedata[NPORT-1:0];
          `PDXM_A_PULL_UP:  pu_reg     <= avs_writedata[NPORT-1:0];
          `PDXM_A_PULL_DN:  pd_reg     <= avs_writedata[NPORT-1:0];
          `PDXM_A_PATH:     path_reg   <= avs_writedata[NPORT-1:0];
          `PDXM_A_EP_CTRL:  ep_reg     <= avs_writedata[3:0];
          `PDXM_A_BC_CTRL:  bc_reg     <= avs_writedata[1:0];
          `PDXM_A_BC_SW:    sw_reg     <= avs_writedata[`PDXM_NSW-1:0];
          `PDXM_A_IRQ_MASK: mask_reg   <= avs_writedata[NPORT-1:0];
          default: ;
        endcase
      end
      if (acc & avs_read) begin
        case (avs_address)
          `PDXM_A_XBAR_DIR: avs_readdata <= {{(32-NPIN){1'b0}}, dir_reg};
          `PDXM_A_XBAR_SEL: avs_readdata <= {14'h0000, sel_reg};
          `PDXM_A_ORIENT:   avs_readdata <= {31'h00000000, orient_reg};
          `PDXM_A_CMP_EN:   avs_readdata <= {{(32-NPORT){1'b0}}, cmp_en_reg};
          `PDXM_A_PULL_UP:  avs_readdata <= {{(32-NPORT){1'b0}}, pu_reg};
          `PDXM_A_PULL_DN:  avs_readdata <= {{(32-NPORT){1'b0}}, pd_reg};
          `PDXM_A_PATH:     avs_readdata <= {{(32-NPORT){1'b0}}, path_reg};
          `PDXM_A_EP_CTRL:  avs_readdata <= {28'h0000000, ep_reg};
          `PDXM_A_BC_CTRL:  avs_readdata <= {30'h00000000, bc_reg};
          `PDXM_A_BC_SW:    avs_readdata <= {20'h00000, sw_reg};
          `PDXM_A_IRQ_STAT: avs_readdata <= {{(32-NPORT){1'b0}}, stat_reg};
          `PDXM_A_IRQ_MASK: avs_readdata <= {{(32-NPORT){1'b0}}, mask_reg};
          `PDXM_A_PIN_STAT: avs_readdata <= {{(32-NPORT){1'b0}}, lvl_s2_reg};
          default:          avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Registered outputs
  wire ep_on = ep_reg[`PDXM_EP_EN];
  wire ep_tx = ep_reg[`PDXM_EP_TX];
  wire dcd   = (bc_reg == `PDXM_BC_DCD);
  wire prisec = (bc_reg == `PDXM_BC_PRI) | (bc_reg == `PDXM_BC_SEC);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq                     <= 1'b0;
      xbar_pin_out            <= {NPIN{1'b0}};
      xbar_pin_oe_n           <= {NPIN{1'b1}};
      sb_sys_to_port          <= 2'h0;
      sb_pin_drive            <= 2'h0;
      cmp_connect             <= {NPORT{1'b0}};
      pull_up_en              <= {NPORT{1'b0}};
      pull_dn_en              <= {NPORT{1'b0}};
      path_closed             <= {NPORT{1'b0}};
      clamp_connect           <= {NPORT{1'b0}};
      ep_drive                <= 2'h0;
      ep_drive_en             <= 1'b0;
      ep_drive_sel            <= 2'h0;
      endpoint_pullup         <= 2'h0;
      ep_rx                   <= 2'h0;
      contact_detect_current  <= 2'h0;
      contact_detect_pulldown <= 2'h0;
      detect_sw               <= {`PDXM_NSW{1'b0}};
      detect_voltage_source   <= 1'b0;
      detect_current_sink     <= 1'b0;
      adc_sample_req          <= 1'b0;
    end else if (ce) begin
      irq           <= |(stat_reg & mask_reg);
      xbar_pin_out  <= xout;
      xbar_pin_oe_n <= ~dir_reg;
      sb_sys_to_port <= s2p;
      // Orientation swaps which sideband pin carries each signal
      sb_pin_drive  <= orient_reg ? {s2p[0], s2p[1]} : s2p;
      cmp_connect   <= cmp_en_reg;
      pull_up_en    <= pu_reg;
      pull_dn_en    <= pd_reg;
      path_closed   <= path_reg;
      clamp_connect <= path_reg;
      // Low-speed only: single pull-up on D-, never D+
      ep_drive_en   <= ep_on & ep_tx;
      ep_drive      <= {ep_reg[`PDXM_EP_DM], ep_reg[`PDXM_EP_DP]};
      ep_drive_sel  <= side_sel(orient_reg);
      endpoint_pullup <= (ep_on & ~ep_tx) ? side_sel(orient_reg) : 2'h0;
      ep_rx         <= orient_reg ? lvl_s2_reg[`PDXM_PORT_BOT +: 2] :
                                    lvl_s2_reg[`PDXM_PORT_TOP +: 2];
      contact_detect_current  <= dcd ? side_sel(orient_reg) : 2'h0;
      contact_detect_pulldown <= dcd ? side_sel(orient_reg) : 2'h0;
      detect_sw             <= prisec ? sw_reg : {`PDXM_NSW{1'b0}};
      detect_voltage_source <= prisec;
      detect_current_sink   <= prisec;
      adc_sample_req        <= prisec;
    end
  end

endmodule // pdxm_top

// ===== tb/pdxm_chk_properties.sv
// Port-level assertions for the crossbar mux control core
`timescale 1ns/1ps
module pdxm_chk (
  // Clock and reset
  input wire       clk,
  input wire       rstn,
  // Register bus
  input wire       avs_read,
  input wire       avs_write,
  input wire       avs_waitrequest,
  // Port controls
  input wire [5:0] path_closed,
  input wire [5:0] clamp_connect,
  input wire [1:0] sb_sys_to_port,
  input wire [1:0] sb_pin_drive,
  // Endpoint and detection
  input wire       ep_drive_en,
  input wire [1:0] endpoint_pullup,
  input wire [1:0] contact_detect_current,
  input wire [1:0] contact_detect_pulldown,
  input wire       detect_voltage_source
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_wait_one_cycle: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_answer_comes: assert property (
    (avs_read || avs_write) && avs_waitrequest |-> ##[0:3] !avs_waitrequest)
    else $error("bus request not answered");
  a_clamp_needs_path: assert property (
    clamp_connect == path_closed)
    else $error("clamp does not follow the closed paths");
  a_tx_pullup_off: assert property (
    ep_drive_en |-> endpoint_pullup == 2'h0)
    else $error("pull-up connected while transmitting");
  a_pullup_one_pin: assert property ($onehot0(endpoint_pullup))
    else $error("pull-up on more than one pin");
  a_dcd_pair_match: assert property (
    contact_detect_current == contact_detect_pulldown && $onehot0(contact_detect_current))
    else $error("contact detect current and pulldown disagree");
  a_phase_exclusive: assert property (
    detect_voltage_source |-> contact_detect_current == 2'h0)
    else $error("voltage source during contact detect");
  a_sb_swap_only: assert property (
    sb_pin_drive == sb_sys_to_port ||
    sb_pin_drive == {sb_sys_to_port[0], sb_sys_to_port[1]})
    else $error("sideband drive is not a swap of the crossbar pair");
endmodule // pdxm_chk
bind pdxm_top pdxm_chk u_chk (.clk(clk), .rstn(rstn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .path_closed(path_closed),
  .clamp_connect(clamp_connect), .sb_sys_to_port(sb_sys_to_port), .sb_pin_drive(sb_pin_drive),
  .ep_drive_en(ep_drive_en), .endpoint_pullup(endpoint_pullup),
  .contact_detect_current(contact_detect_current),
  .contact_detect_pulldown(contact_detect_pulldown),
  .detect_voltage_source(detect_voltage_source));

// ===== tb/pdxm_partner.sv
// Far-side model: system pin wires and port pin levels
`timescale 1ns/1ps
module pdxm_partner (
  // Clock and reset
  input  wire       clk,
  input  wire       rstn,
  // System pins
  input  wire [5:0] sys_val,
  input  wire [5:0] pin_out,
  input  wire [5:0] pin_oe_n,
  output wire [5:0] pin_in,
  // Port side
  input  wire [5:0] flip,
  output reg  [5:0] level
);
  // Wire level: the core wins where it drives
  assign pin_in = (pin_oe_n & sys_val) | (~pin_oe_n & pin_out);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) level <= 6'h00;
    else level <= level ^ flip;
  end
endmodule // pdxm_partner

// ===== tb/tb_port_data_crossbar_mux.sv
// Self-checking bench for the crossbar mux control core
`timescale 1ns/1ps
module tb_port_data_crossbar_mux;
  logic clk, rstn, avs_read, avs_write, avs_waitrequest, irq, ep_drive_en, vsrc, isnk, adc;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [5:0]  pin_in, pin_out, pin_oe_n, sys_val, flip, level, cmp, pu, pd, path, clamp;
  logic [1:0]  sb_in, sb_s2p, sb_drv, ep_drv, ep_sel, ep_pu, ep_rx, dcd_i, dcd_pd;
  logic [11:0] dsw;
  int num_errors, check_count;
  pdxm_top u_dut (.clk(clk), .rstn(rstn), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .xbar_pin_in(pin_in), .xbar_pin_out(pin_out), .xbar_pin_oe_n(pin_oe_n),
    .sb_sys_to_port(sb_s2p), .sb_pin_drive(sb_drv), .sideband_port_to_sys(sb_in),
    .port_level(level), .cmp_connect(cmp), .pull_up_en(pu), .pull_dn_en(pd),
    .path_closed(path), .clamp_connect(clamp), .ep_drive(ep_drv), .ep_drive_en(ep_drive_en),
    .ep_drive_sel(ep_sel), .endpoint_pullup(ep_pu), .ep_rx(ep_rx),
    .contact_detect_current(dcd_i), .contact_detect_pulldown(dcd_pd), .detect_sw(dsw),
    .detect_voltage_source(vsrc), .detect_current_sink(isnk), .adc_sample_req(adc));
  pdxm_partner u_far (.clk(clk), .rstn(rstn), .sys_val(sys_val), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_in(pin_in), .flip(flip), .level(level));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task conclude();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task hold();
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      num_errors++;
      conclude();
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    hold();
    avs_write <= 1'b0;
  endtask
  task rd(input [3:0] a, input [31:0] e);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    hold();
    chk($sformatf("reg %0h", a), e, avs_readdata);
    avs_read <= 1'b0;
  endtask
  // Settle a few edges, then look just after the edge
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task pulse(input [5:0] m);
    @(posedge clk);
    flip <= m;
    @(posedge clk);
    flip <= 6'h00;
    wt(8);
  endtask
  initial begin
    {rstn, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {sys_val, flip, sb_in, num_errors, check_count} = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a < 12; a++) rd(a, (a == 0) ? 32'h2 : 32'h0);
    sys_val <= 6'h01;
    wt(5);
    chk("tx bypass", 2'h3, {pin_out[1], ~pin_oe_n[1]});
    wr(4'hD, 32'hFFFF);
    rd(4'hD, 32'h0);
    $display("test reset and bypass done");
    wr(0, 32'h22);
    wr(1, 32'h20000);
    sys_val <= 6'h11;
    wt(5);
    chk("gp routed", 6'h22, pin_out & 6'h22);
    chk("oe_n", 6'h1D, pin_oe_n);
    wr(1, 32'h3E000);
    sb_in <= 2'h1;
    wr(2, 32'h1);
    wt(5);
    chk("sb s2p", 2'h1, sb_s2p);
    chk("sb swapped", 2'h2, sb_drv);
    wr(7, 32'h1);
    wt(1);
    chk("rx pullup b", 2'h2, ep_pu);
    wr(7, 32'hF);
    wt(1);
    chk("tx pullup", 2'h0, ep_pu);
    chk("tx drive", 5'h1B, {ep_drive_en, ep_sel, ep_drv});
    wr(7, 32'h1);
    wr(2, 32'h0);
    wt(1);
    chk("rx pullup t", 2'h1, ep_pu);
    chk("sb straight", 2'h1, sb_drv);
    $display("test routing and endpoint done");
    for (int p = 0; p < 4; p++) begin
      wr(8, p);
      wt(1);
      chk("dcd", (p == 1) ? 4'h5 : 4'h0, {dcd_i, dcd_pd});
      chk("vsrc isnk adc", (p > 1) ? 3'h7 : 3'h0, {vsrc, isnk, adc});
    end
    wr(9, 32'hA5A);
    wt(1);
    chk("switches", 12'hA5A, dsw);
    rd(9, 32'hA5A);
    wr(4, 32'h2A);
    wr(5, 32'h15);
    wr(6, 32'h0F);
    wt(1);
    chk("pulls", 18'h2A54F, {pu, pd, path});
    chk("clamp", 6'h0F, clamp);
    $display("test detection and pulls done");
    wr(3, 32'h4);
    wr(4'hB, 32'h4);
    pulse(6'h04);
    chk("irq set", 2'h3, {cmp == 6'h04, irq});
    rd(4'hA, 32'h4);
    wr(4'hA, 32'h4);
    wt(2);
    chk("irq clear", 0, irq);
    wr(4'hB, 32'h0);
    pulse(6'h04);
    chk("irq masked", 0, irq);
    rd(4'hA, 32'h4);
    wr(4'hA, 32'h4);
    pulse(6'h08);
    rd(4'hA, 32'h0);
    rd(4'hC, 32'h8);
    chk("ep rx", 2'h2, ep_rx);
    $display("test interrupts done");
    conclude();
  end
endmodule // tb_port_data_crossbar_mux
